// ===== dv/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    input  wire logic  i_clk,     // Reference clock
    input  wire logic  i_ready,   // Char taken at next edge
    output logic [7:0] o_char,    // Offered ASCII char
    output logic       o_serial,  // Char travels on serial link
    output logic       o_valid    // Char offered
);
    // Idle lines at time zero
    initial begin
        o_char = 8'hFF;
        o_serial = 1'b0;
        o_valid = 1'b0;
    end
    // Offer one char after a stall, hold it until taken
    task automatic send(input logic [7:0] c, input logic ser, input int stall);
        if (stall > 0) idle();
        repeat (stall) @(negedge i_clk);
        o_char = c;
        o_serial = ser;
        o_valid = 1'b1;
        while (i_ready !== 1'b1) @(negedge i_clk);
        @(negedge i_clk);
    endtask
    // Release the line, stale value inverted
    task automatic idle();
        o_valid = 1'b0;
        o_char = ~o_char;
    endtask
endmodule // host_model
`default_nettype wire

// ===== dv/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic        clk, resetn, rx_serial, rx_valid, rx_ready, exec_done, err_read, go_remote, lockout;
    logic        key_valid, key_local, cmd_valid, cmd_common, cmd_query, data_valid, param_end;
    logic        err, err_serial, err_pending, prompt, remote, key_out_valid;
    logic [7:0]  rx_char, key_code, data_char, key_out_code, kc;
    logic [31:0] cmd_name, cname, dstr;
    logic [8:0]  hdr_path, cpath;
    logic [3:0]  param_index, lidx;
    logic [1:0]  hdr_depth, cdep, cflags;
    int          n_fail = 0;
    int          n_tests = 0;
    int          seed = 32'hab51;
    int          r;
    int          cnt[5];  // Commands, errors, serial errors, prompts, parameter ends
    string       fill;

    text_command_parser dut (
        .I_REF_CLK(clk), .I_RESETN(resetn), .I_RX_CHAR(rx_char), .I_RX_SERIAL(rx_serial),
        .I_RX_VALID(rx_valid), .O_RX_READY(rx_ready), .I_EXEC_DONE(exec_done), .I_ERR_READ(err_read),
        .I_GO_REMOTE(go_remote), .I_LOCKOUT(lockout), .I_KEY_VALID(key_valid), .I_KEY_CODE(key_code),
        .I_KEY_IS_LOCAL(key_local), .O_CMD_VALID(cmd_valid), .O_CMD_COMMON(cmd_common),
        .O_CMD_QUERY(cmd_query), .O_CMD_NAME(cmd_name), .O_HDR_PATH(hdr_path), .O_HDR_DEPTH(hdr_depth),
        .O_DATA_VALID(data_valid), .O_DATA_CHAR(data_char), .O_PARAM_INDEX(param_index),
        .O_PARAM_END(param_end), .O_ERR(err), .O_ERR_SERIAL(err_serial), .O_ERR_PENDING(err_pending),
        .O_PROMPT(prompt), .O_REMOTE(remote), .O_KEY_VALID(key_out_valid), .O_KEY_CODE(key_out_code)
    );
    host_model host (.i_clk(clk), .i_ready(rx_ready), .o_char(rx_char), .o_serial(rx_serial), .o_valid(rx_valid));

    // 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // Gather output events where they are settled
    always @(negedge clk) begin
        if (cmd_valid === 1'b1) begin
            cnt[0]++;
            cflags = {cmd_common, cmd_query};
            cname = cmd_name;
            cpath = hdr_path;
            cdep = hdr_depth;
        end
        if (data_valid === 1'b1) begin
            dstr = {dstr[23:0], data_char};
            lidx = param_index;
        end
        if (err === 1'b1) cnt[1]++;
        if (err_serial === 1'b1) cnt[2]++;
        if (prompt === 1'b1) cnt[3]++;
        if (param_end === 1'b1) cnt[4]++;
    end
    task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    // Execution done, then time to drain
    task automatic done_pulse();
        exec_done = 1'b1;
        @(negedge clk);
        exec_done = 1'b0;
        repeat (40) @(negedge clk);
    endtask
    // One message with line feed, random stalls
    task automatic msg(string s, logic ser, bit hold = 0);
        cnt = '{default: 0};
        dstr = '0;
        for (int i = 0; i <= s.len(); i++) host.send((i < s.len()) ? s[i] : 8'h0A, ser, $unsigned($random(seed)) % 3);
        host.idle();
        repeat (8) @(negedge clk);
        if (!hold) done_pulse();
        $display("test done: %s", s);
    endtask
    // One panel key, answer seen a cycle later
    task automatic key(logic [7:0] code, logic loc, logic exp_kv, logic exp_rmt);
        key_valid = 1'b1;
        key_code = code;
        key_local = loc;
        @(negedge clk);
        key_valid = 1'b0;
        chk("key accepted", exp_kv, key_out_valid);
        if (exp_kv) chk("key code", code, key_out_code);
        chk("remote", exp_rmt, remote);
        @(negedge clk);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Hang guard
    initial begin
        #100000;
        n_fail++;
        $display("ERROR watchdog expected finish seen timeout");
        tally_and_finish();
    end
    // Main sequence
    initial begin
        {resetn, exec_done, err_read, go_remote, lockout, key_valid, key_local} = '0;
        key_code = 8'h00;
        repeat (10) @(negedge clk);
        resetn = 1'b1;
        @(negedge clk);
        msg("*rst", 1'b1);
        chk("common", 2'b10, cflags);
        chk("name", 24'h525354, cname[23:0]);
        chk("prompt", 1, cnt[3]);
        msg(":DISP:ENAB ON", 1'b0);
        chk("path", {2'd2, 3'd5, 3'd4}, {cdep, cpath[5:0]});
        chk("data", 16'h4F4E, dstr[15:0]);
        chk("no prompt", 0, cnt[3]);
        msg(":display:EnAbLe?", 1'b1);
        chk("query", 2'b01, cflags);
        chk("path", 6'({3'd5, 3'd4}), cpath[5:0]);
        for (int k = 0; k < 4; k++) begin
            r = $random(seed);
            msg(k[0] ? ":SENS:FREQ:RES 1,2" : ":freq:res 1,2", r[0]);
            chk("path", {2'd3, 3'd3, 3'd2, 3'd1}, {cdep, cpath});
            chk("params", {4'd1, 16'h3132}, {lidx, dstr[15:0]});
            chk("param ends", 2, cnt[4]);
            chk("prompt", r[0], cnt[3]);
        end
        for (int k = 0; k < 2; k++) begin
            msg(":DISPL:ENAB 1;:INP:COUP AC", k[0]);
            chk("errors", 1, cnt[1]);
            chk("commands", 1, cnt[0]);
            chk("serial errors", k, cnt[2]);
            chk("pending", !k[0], err_pending);
            err_read = 1'b1;
            @(negedge clk);
            err_read = 1'b0;
            @(negedge clk);
            chk("pending cleared", 0, err_pending);
        end
        msg(":DISP:ENAB 1;:INP:COUP AC", 1'b0);
        chk("commands", 2, cnt[0]);
        chk("path", {3'd7, 3'd6}, cpath[5:0]);
        msg("*CLS", 1'b0, 1);
        fill = "*OPC;*WAI;*ESE1\n";
        foreach (fill[i]) host.send(fill[i], 1'b0, 0);
        chk("buffer full", 0, rx_ready);
        host.idle();
        done_pulse();
        done_pulse();
        chk("commands", 4, cnt[0]);
        kc = 8'($random(seed));
        key(kc, 1'b0, 1'b1, 1'b0);
        go_remote = 1'b1;
        @(negedge clk);
        go_remote = 1'b0;
        chk("remote", 1, remote);
        key(kc, 1'b0, 1'b0, 1'b1);
        lockout = 1'b1;
        key(kc, 1'b1, 1'b0, 1'b1);
        lockout = 1'b0;
        key(kc, 1'b1, 1'b0, 1'b0);
        $display("test done: panel");
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire

// ===== dv/text_command_parser_chk.sv
`timescale 1ns/1ps
`default_nettype none
module text_command_parser_chk (
    input wire logic       I_REF_CLK,
    input wire logic       I_RESETN,
    input wire logic       I_EXEC_DONE,
    input wire logic       I_GO_REMOTE,
    input wire logic       I_LOCKOUT,
    input wire logic       I_KEY_VALID,
    input wire logic [7:0] I_KEY_CODE,
    input wire logic       I_KEY_IS_LOCAL,
    input wire logic       O_CMD_VALID,
    input wire logic       O_CMD_COMMON,
    input wire logic       O_DATA_VALID,
    input wire logic [7:0] O_DATA_CHAR,
    input wire logic       O_ERR,
    input wire logic       O_ERR_SERIAL,
    input wire logic       O_ERR_PENDING,
    input wire logic       O_PROMPT,
    input wire logic       O_REMOTE,
    input wire logic       O_KEY_VALID,
    input wire logic [7:0] O_KEY_CODE
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    // Local keys pass with their code, remote ones are dropped
    property p_local_key; I_KEY_VALID && !O_REMOTE && !I_GO_REMOTE |=> O_KEY_VALID && O_KEY_CODE == $past(I_KEY_CODE); endproperty
    a_local_key: assert property (p_local_key)
        else $error("local key not passed");
    property p_rmt_key; I_KEY_VALID && O_REMOTE |=> !O_KEY_VALID; endproperty
    a_rmt_key: assert property (p_rmt_key)
        else $error("key passed in remote");
    // Return to local only without lockout
    property p_ret_local; O_REMOTE && I_KEY_VALID && I_KEY_IS_LOCAL && !I_LOCKOUT && !I_GO_REMOTE |=> !O_REMOTE; endproperty
    a_ret_local: assert property (p_ret_local)
        else $error("local key ignored");
    property p_lockout; O_REMOTE && I_LOCKOUT |=> O_REMOTE; endproperty
    a_lockout: assert property (p_lockout)
        else $error("remote left under lockout");
    property p_go_remote; I_GO_REMOTE |=> O_REMOTE; endproperty
    a_go_remote: assert property (p_go_remote)
        else $error("indicator not lit");
    // Error reporting split by source
    property p_err_ser; O_ERR_SERIAL |-> O_ERR; endproperty
    a_err_ser: assert property (p_err_ser)
        else $error("serial error without error");
    property p_err_pend; O_ERR && !O_ERR_SERIAL |-> O_ERR_PENDING; endproperty
    a_err_pend: assert property (p_err_pend)
        else $error("parallel error not held");
    // Prompt follows execution by one cycle
    property p_prompt; O_PROMPT |-> $past(I_EXEC_DONE); endproperty
    a_prompt: assert property (p_prompt)
        else $error("prompt without execution");
    // Commas never reach the data stream
    property p_comma; O_DATA_VALID |-> O_DATA_CHAR != 8'h2C; endproperty
    a_comma: assert property (p_comma)
        else $error("comma passed as data");

    c_common: cover property (O_CMD_VALID && O_CMD_COMMON);
    c_err: cover property (O_ERR_SERIAL);
    c_local: cover property ($fell(O_REMOTE));
endmodule // text_command_parser_chk

bind text_command_parser text_command_parser_chk u_chk (
    .I_REF_CLK(I_REF_CLK), .I_RESETN(I_RESETN), .I_EXEC_DONE(I_EXEC_DONE), .I_GO_REMOTE(I_GO_REMOTE),
    .I_LOCKOUT(I_LOCKOUT), .I_KEY_VALID(I_KEY_VALID), .I_KEY_CODE(I_KEY_CODE), .I_KEY_IS_LOCAL(I_KEY_IS_LOCAL),
    .O_CMD_VALID(O_CMD_VALID), .O_CMD_COMMON(O_CMD_COMMON), .O_DATA_VALID(O_DATA_VALID),
    .O_DATA_CHAR(O_DATA_CHAR), .O_ERR(O_ERR), .O_ERR_SERIAL(O_ERR_SERIAL), .O_ERR_PENDING(O_ERR_PENDING),
    .O_PROMPT(O_PROMPT), .O_REMOTE(O_REMOTE), .O_KEY_VALID(O_KEY_VALID), .O_KEY_CODE(O_KEY_CODE)
);
`default_nettype wire

// ===== logic/char_fifo.sv
`timescale 1ns/1ps
`default_nettype none
`include "text_command_parser_regs.svh"
module char_fifo
    import text_command_parser_pkg::*;
#(
    parameter int W = `TCP_FIFO_W,
    parameter int D = `TCP_FIFO_D
) (
    input  wire logic         i_clk,
    input  wire logic         i_resetn,
    input  wire logic [W-1:0] i_data,
    input  wire logic         i_valid,
    output logic              o_ready,
    output logic [W-1:0]      o_data,
    output logic              o_valid,
    input  wire logic         i_ready
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];  // Character storage
    fifo_t        r;        // Registered pointers
    fifo_t        next_r;   // Next pointers
    logic         push;     // Write this cycle
    logic         pop;      // Read this cycle
    logic [AW:0]  used;     // Next occupancy

    assign o_valid = (r.wp != r.rp);
    assign o_ready = r.in_ready;
    assign o_data  = mem[r.rp[AW-1:0]];

    // Pointer update and registered full flag
    always_comb begin
        push   = i_valid && r.in_ready;
        pop    = o_valid && i_ready;
        next_r = r;
        if (push) begin
            next_r.wp = r.wp + 5'h01;
        end
        if (pop) begin
            next_r.rp = r.rp + 5'h01;
        end
        used            = next_r.wp[AW:0] - next_r.rp[AW:0];
        next_r.in_ready = (used != (AW+1)'(D));
    end

    // State register
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            r <= '{wp: 5'h00, rp: 5'h00, in_ready: 1'b1};
        end else begin
            r <= next_r;
        end
    end

    // Storage write, no reset needed
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[r.wp[AW-1:0]] <= i_data;
        end
    end
endmodule // char_fifo
`default_nettype wire

// ===== logic/text_command_parser.sv
`timescale 1ns/1ps
`default_nettype none
`include "text_command_parser_regs.svh"
module text_command_parser
    import text_command_parser_pkg::*;
(
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESETN,
    input  wire logic [7:0]  I_RX_CHAR,
    input  wire logic        I_RX_SERIAL,
    input  wire logic        I_RX_VALID,
    output logic             O_RX_READY,
    input  wire logic        I_EXEC_DONE,
    input  wire logic        I_ERR_READ,
    input  wire logic        I_GO_REMOTE,
    input  wire logic        I_LOCKOUT,
    input  wire logic        I_KEY_VALID,
    input  wire logic [7:0]  I_KEY_CODE,
    input  wire logic        I_KEY_IS_LOCAL,
    output logic             O_CMD_VALID,
    output logic             O_CMD_COMMON,
    output logic             O_CMD_QUERY,
    output logic [31:0]      O_CMD_NAME,
    output logic [8:0]       O_HDR_PATH,
    output logic [1:0]       O_HDR_DEPTH,
    output logic             O_DATA_VALID,
    output logic [7:0]       O_DATA_CHAR,
    output logic [3:0]       O_PARAM_INDEX,
    output logic             O_PARAM_END,
    output logic             O_ERR,
    output logic             O_ERR_SERIAL,
    output logic             O_ERR_PENDING,
    output logic             O_PROMPT,
    output logic             O_REMOTE,
    output logic             O_KEY_VALID,
    output logic [7:0]       O_KEY_CODE
);
    parse_t                r;          // Registered state
    parse_t                next_r;     // Next state
    logic [8:0]            ff_data;    // FIFO head
    logic                  ff_valid;   // FIFO has a char
    logic                  ff_ready;   // Parser takes the char
    logic [7:0]            ch;         // Raw char
    logic [7:0]            uc;         // Upper-cased char
    logic                  lk_ok;      // Keyword legal here
    logic                  lk_ins;     // Optional parent implied
    kw_id_t                lk_id;      // Matched keyword
    kw_id_t                lk_par;     // Its parent
    logic                  cl_bad;     // Closing keyword is illegal
    logic [`TCP_DEPTH-1:0][2:0] cl_path;  // Path after close
    logic [1:0]            cl_depth;   // Depth after close
    logic                  hdr_any;    // Something seen in header

    // Either interface feeds one buffer of ASCII chars
    char_fifo #(
        .W (`TCP_FIFO_W),
        .D (`TCP_FIFO_D)
    ) u_fifo (
        .i_clk    (I_REF_CLK),
        .i_resetn (I_RESETN),
        .i_data   ({I_RX_SERIAL, I_RX_CHAR}),
        .i_valid  (I_RX_VALID),
        .o_ready  (O_RX_READY),
        .o_data   (ff_data),
        .o_valid  (ff_valid),
        .i_ready  (ff_ready)
    );

    // Keyword table: long spelling, long length, short length, parent, optional
    function automatic logic [91:0] kw_tab(input int i);
        case (i)
            1:       kw_tab = {"SENSE     ", 4'h5, 4'h4, 3'h0, 1'b1};
            2:       kw_tab = {"FREQUENCY ", 4'h9, 4'h4, 3'h1, 1'b0};
            3:       kw_tab = {"RESOLUTION", 4'hA, 4'h3, 3'h2, 1'b0};
            4:       kw_tab = {"DISPLAY   ", 4'h7, 4'h4, 3'h0, 1'b0};
            5:       kw_tab = {"ENABLE    ", 4'h6, 4'h4, 3'h4, 1'b0};
            6:       kw_tab = {"INPUT     ", 4'h5, 4'h3, 3'h0, 1'b0};
            7:       kw_tab = {"COUPLING  ", 4'h8, 4'h4, 3'h6, 1'b0};
            default: kw_tab = '0;
        endcase
    endfunction

    // Keyword lookup against the buffered spelling
    always_comb begin
        logic [91:0] e;
        logic [91:0] pe;
        logic        same;
        kw_id_t      want;
        e      = '0;
        pe     = '0;
        same   = 1'b0;
        lk_ok  = 1'b0;
        lk_ins = 1'b0;
        lk_id  = 3'h0;
        lk_par = 3'h0;
        want   = (r.depth == 2'h0) ? 3'h0 : r.path[r.depth - 2'h1];
        for (int i = 1; i <= `TCP_KW_COUNT; i++) begin
            e    = kw_tab(i);
            pe   = kw_tab(int'(e[3:1]));  // Parent entry, zero for roots
            same = 1'b1;
            // Compare only the chars the host sent
            for (int j = 0; j < `TCP_KW_MAX; j++) begin
                if (4'(j) < r.klen && r.kbuf[j] != e[91-8*j -: 8]) begin
                    same = 1'b0;
                end
            end
            // Exactly short or long length, partial lengths fail
            if (same && !r.kovf && (r.klen == e[7:4] || r.klen == e[11:8])) begin
                if (e[3:1] == want) begin
                    lk_ok  = 1'b1;
                    lk_id  = 3'(i);
                    lk_ins = 1'b0;
                end else if (r.depth == 2'h0 && e[3:1] != 3'h0 && pe[0]) begin
                    // Child of an optional root arriving first
                    lk_ok  = 1'b1;
                    lk_id  = 3'(i);
                    lk_par = e[3:1];
                    lk_ins = 1'b1;
                end
            end
        end
    end

    // Effect of ending the current keyword
    always_comb begin
        cl_path  = r.path;
        cl_depth = r.depth;
        cl_bad   = 1'b0;
        if (!r.common && r.klen != 4'h0) begin
            if (!lk_ok || r.depth == 2'(`TCP_DEPTH)) begin
                cl_bad = 1'b1;
            end else if (lk_ins) begin
                cl_path[0] = lk_par;
                cl_path[1] = lk_id;
                cl_depth   = 2'h2;
            end else begin
                cl_path[r.depth] = lk_id;
                cl_depth         = r.depth + 2'h1;
            end
        end
        if (r.common && r.kovf) begin
            cl_bad = 1'b1;
        end
    end

    assign ch       = ff_data[7:0];
    assign uc       = (ch >= `TCP_CH_LC_A && ch <= `TCP_CH_LC_Z) ? ch - `TCP_CASE_OFS : ch;
    assign ff_ready = (r.st != ST_WAIT);
    assign hdr_any  = r.common || r.klen != 4'h0 || r.depth != 2'h0;

    // Next state of panel, parser and event outputs
    always_comb begin
        next_r            = r;
        next_r.cmd_valid  = 1'b0;
        next_r.err        = 1'b0;
        next_r.err_serial = 1'b0;
        next_r.prompt     = 1'b0;
        next_r.data_valid = 1'b0;
        next_r.param_end  = 1'b0;
        next_r.key_valid  = 1'b0;

        // Remote and local control of the panel
        if (I_GO_REMOTE) begin
            next_r.remote = 1'b1;
        end else if (I_KEY_VALID && r.remote) begin
            if (I_KEY_IS_LOCAL && !I_LOCKOUT) begin
                next_r.remote = 1'b0;
            end
        end else if (I_KEY_VALID) begin
            next_r.key_valid = 1'b1;                        // Local mode: keys act
            next_r.key_code  = I_KEY_CODE;
        end
        // Remote keys never reach key_valid

        // Error report read by the parallel host
        if (I_ERR_READ) begin
            next_r.err_pend = 1'b0;
        end

        if (ff_valid && ff_ready) begin
            next_r.serial = ff_data[8];
            case (r.st)
                ST_HDR: begin
                    if (ch == `TCP_CH_STAR && !hdr_any) begin
                        next_r.common = 1'b1;
                    end else if (ch == `TCP_CH_COLON) begin
                        if (r.klen == 4'h0 && !r.common) begin
                            next_r.depth = 2'h0;            // Leading colon
                        end else begin
                            next_r.path  = cl_path;
                            next_r.depth = cl_depth;
                            next_r.klen  = 4'h0;
                            next_r.err   = cl_bad || r.common;
                            if (cl_bad || r.common) begin
                                next_r.st = ST_SKIP;
                            end
                        end
                    end else if (ch == `TCP_CH_QMARK) begin
                        next_r.query = 1'b1;
                    end else if (ch == `TCP_CH_SPACE || ch == `TCP_CH_SEMI || ch == `TCP_CH_LF) begin
                        next_r.path   = cl_path;
                        next_r.depth  = cl_depth;
                        next_r.klen   = 4'h0;
                        next_r.err    = cl_bad;
                        next_r.cmd_valid = !cl_bad && hdr_any;
                        next_r.pidx   = 4'h0;
                        if (cl_bad) begin
                            next_r.st = ST_SKIP;
                        end else if (ch == `TCP_CH_SPACE && hdr_any) begin
                            next_r.st = ST_PARAM;           // Header-to-data delimiter
                        end
                        if (ch == `TCP_CH_SEMI && !cl_bad) begin
                            // Next command keeps the parent path
                            next_r.depth  = (cl_depth == 2'h0) ? 2'h0 : cl_depth - 2'h1;
                            next_r.common = 1'b0;
                            next_r.query  = 1'b0;
                        end
                        if (ch == `TCP_CH_LF) begin
                            next_r.st = ST_WAIT;
                        end
                    end else if (r.klen == 4'(`TCP_KW_MAX)) begin
                        next_r.kovf = 1'b1;                 // Too long for any keyword
                    end else begin
                        next_r.kbuf[r.klen] = uc;
                        next_r.klen = r.klen + 4'h1;
                        if (r.common && r.klen < 4'h4) begin
                            next_r.name = {r.name[23:0], uc};
                        end
                    end
                end
                ST_PARAM: begin
                    if (ch == `TCP_CH_COMMA) begin
                        next_r.param_end = 1'b1;
                        next_r.pidx = r.pidx + 4'h1;
                    end else if (ch == `TCP_CH_SEMI) begin
                        next_r.param_end = 1'b1;
                        next_r.st     = ST_HDR;
                        next_r.depth  = (r.depth == 2'h0) ? 2'h0 : r.depth - 2'h1;
                        next_r.common = 1'b0;
                        next_r.query  = 1'b0;
                    end else if (ch == `TCP_CH_LF) begin
                        next_r.param_end = 1'b1;
                        next_r.st = ST_WAIT;
                    end else begin
                        next_r.data_valid = 1'b1;
                        next_r.data_char  = ch;
                    end
                end
                ST_SKIP: begin
                    // Drop the rest of a bad command
                    if (ch == `TCP_CH_SEMI) begin
                        next_r.st     = ST_HDR;
                        next_r.depth  = 2'h0;
                        next_r.common = 1'b0;
                        next_r.query  = 1'b0;
                        next_r.klen   = 4'h0;
                        next_r.kovf   = 1'b0;
                    end else if (ch == `TCP_CH_LF) begin
                        next_r.st = ST_WAIT;
                    end
                end
                default: begin
                    next_r.st = ST_WAIT;
                end
            endcase
            if (next_r.st != ST_HDR || ch == `TCP_CH_SEMI) begin
                next_r.kovf = 1'b0;
            end
        end

        // Message done: wait for execution, then prompt on serial
        if (r.st == ST_WAIT && I_EXEC_DONE) begin
            next_r.prompt = r.serial;
            next_r.st     = ST_HDR;
            next_r.depth  = 2'h0;
            next_r.common = 1'b0;
            next_r.query  = 1'b0;
            next_r.klen   = 4'h0;
            next_r.kovf   = 1'b0;
        end

        // Error delivery depends on the interface
        if (next_r.err) begin
            next_r.err_serial = next_r.serial;
            if (!next_r.serial) begin
                next_r.err_pend = 1'b1;                     // Set wins over read
            end
        end
    end

    // State register
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs taken straight from the state register
    assign O_CMD_VALID   = r.cmd_valid;
    assign O_CMD_COMMON  = r.common;
    assign O_CMD_QUERY   = r.query;
    assign O_CMD_NAME    = r.name;
    assign O_HDR_PATH    = r.path;
    assign O_HDR_DEPTH   = r.depth;
    assign O_DATA_VALID  = r.data_valid;
    assign O_DATA_CHAR   = r.data_char;
    assign O_PARAM_INDEX = r.pidx;
    assign O_PARAM_END   = r.param_end;
    assign O_ERR         = r.err;
    assign O_ERR_SERIAL  = r.err_serial;
    assign O_ERR_PENDING = r.err_pend;
    assign O_PROMPT      = r.prompt;
    assign O_REMOTE      = r.remote;
    assign O_KEY_VALID   = r.key_valid;
    assign O_KEY_CODE    = r.key_code;
endmodule // text_command_parser
`default_nettype wire

// ===== logic/text_command_parser_pkg.sv
`default_nettype none
package text_command_parser_pkg;
`include "text_command_parser_regs.svh"

    // Parser states
    typedef enum logic [1:0] {ST_HDR, ST_PARAM, ST_SKIP, ST_WAIT} pstate_t;

    // Keyword identity, zero means none
    typedef logic [2:0] kw_id_t;

    // Whole parser state
    typedef struct packed {
        pstate_t                          st;         // Parse phase
        logic [`TCP_KW_MAX-1:0][7:0]      kbuf;       // Upper-cased keyword
        logic [3:0]                       klen;       // Keyword length
        logic                             kovf;       // Keyword too long
        logic [`TCP_DEPTH-1:0][2:0]       path;       // Header path ids
        logic [1:0]                       depth;      // Path depth
        logic                             common;     // Star command
        logic                             query;      // Header ended in ?
        logic                             serial;     // Char came from serial
        logic [31:0]                      name;       // Common command name
        logic [3:0]                       pidx;       // Parameter number
        logic                             remote;     // Remote mode
        logic                             cmd_valid;  // Header done pulse
        logic                             err;        // Error pulse
        logic                             err_serial; // Unprompted error send
        logic                             err_pend;   // Error awaiting request
        logic                             prompt;     // Serial prompt pulse
        logic                             data_valid; // Parameter char pulse
        logic [7:0]                       data_char;  // Parameter char
        logic                             param_end;  // Parameter closed
        logic                             key_valid;  // Panel key accepted
        logic [7:0]                       key_code;   // Accepted key code
    } parse_t;

    // Character FIFO pointers
    typedef struct packed {
        logic [4:0] wp;       // Write pointer with wrap bit
        logic [4:0] rp;       // Read pointer with wrap bit
        logic       in_ready; // Registered not-full
    } fifo_t;

endpackage
`default_nettype wire

// ===== logic/text_command_parser_regs.svh
`ifndef TEXT_COMMAND_PARSER_REGS_SVH
`define TEXT_COMMAND_PARSER_REGS_SVH

// Delimiter characters of the command language
`define TCP_CH_SPACE 8'h20
`define TCP_CH_COLON 8'h3A
`define TCP_CH_SEMI  8'h3B
`define TCP_CH_COMMA 8'h2C
`define TCP_CH_QMARK 8'h3F
`define TCP_CH_STAR  8'h2A
`define TCP_CH_LF    8'h0A
// Lower case letter range and case offset
`define TCP_CH_LC_A  8'h61
`define TCP_CH_LC_Z  8'h7A
`define TCP_CASE_OFS 8'h20

// Longest keyword held, in characters
`define TCP_KW_MAX   10
// Entries of the keyword table
`define TCP_KW_COUNT 7
// Deepest header path
`define TCP_DEPTH    3
// Character buffer shape: source bit plus one byte
`define TCP_FIFO_W   9
`define TCP_FIFO_D   16

`endif
